// ==== hw/alu_branch_core.sv ====
/*
 * Execution sequencer for the add, shift, bit-clear, skip and relative jump subset.
 * Assumes the file-register array is outside: it supplies fval for faddr in the
 * same cycle and accepts a write pulse. Instruction words arrive decoded.
 */
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_branch_core (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Decoded instruction
  input  wire logic               instr_valid,
  input  wire alu_pkg::op_t       instr_op,
  input  wire logic [6:0]         instr_faddr,
  input  wire logic               instr_dest,
  input  wire logic [2:0]         instr_bit,
  input  wire logic [8:0]         instr_rel,
  // File register port
  output logic [6:0]              file_addr,
  input  wire logic [7:0]         file_rdata,
  output logic                    file_we,
  output logic [7:0]              file_wdata,
  // Architectural state
  output logic [7:0]              acc,
  output logic                    carry,
  output logic                    nibble_overflow_flag,
  output logic                    zero,
  output logic [14:0]             pc,
  // Flow control
  output logic                    busy,
  output logic                    discard_next
);
  alu_if bus ();

  alu_unit u_unit (
    .a (bus.unit)
  );

  alu_pkg::exec_state_t st_r;
  alu_pkg::exec_state_t st_nxt;
  logic [7:0]           acc_r;
  logic [7:0]           acc_nxt;
  logic                 c_r;
  logic                 c_nxt;
  logic                 dc_r;
  logic                 dc_nxt;
  logic                 z_r;
  logic                 z_nxt;
  logic [14:0]          pc_r;
  logic [14:0]          pc_nxt;
  logic                 we_r;
  logic                 we_nxt;
  logic [7:0]           wd_r;
  logic [7:0]           wd_nxt;
  logic [6:0]           wa_r;
  logic [6:0]           wa_nxt;
  logic                 disc_r;
  logic                 disc_nxt;

  // Sign-extend a relative offset to PC width
  function automatic logic [14:0] sext_rel(input logic [8:0] k);
    sext_rel = {{6{k[8]}}, k};
  endfunction

  assign bus.op       = instr_op;
  assign bus.acc      = acc_r;
  assign bus.fval     = file_rdata;
  assign bus.bit_sel  = instr_bit;
  assign bus.carry_in = c_r;

  always_comb begin
    st_nxt   = st_r;
    acc_nxt  = acc_r;
    c_nxt    = c_r;
    dc_nxt   = dc_r;
    z_nxt    = z_r;
    pc_nxt   = pc_r;
    we_nxt   = 1'b0;
    wd_nxt   = wd_r;
    wa_nxt   = wa_r;
    disc_nxt = 1'b0;
    case (st_r)
      alu_pkg::ST_EXEC: begin
        if (instr_valid) begin
          // PC points at the next word once an instruction is taken
          pc_nxt = pc_r + 15'h0001;
          case (instr_op)
            alu_pkg::OP_ADD, alu_pkg::OP_ADDC, alu_pkg::OP_ASR, alu_pkg::OP_BCLR: begin
              if (instr_dest) begin
                we_nxt = 1'b1;
                wd_nxt = bus.result;
                wa_nxt = instr_faddr;
              end else begin
                acc_nxt = bus.result;
              end
              if (bus.writes_c) begin
                c_nxt = bus.carry_out;
              end
              if (bus.writes_dcz) begin
                dc_nxt = bus.nib_out;
              end
              if (bus.writes_z) begin
                z_nxt = bus.zero_out;
              end
            end
            alu_pkg::OP_SKPL: begin
              if (bus.test_low) begin
                st_nxt   = alu_pkg::ST_FLUSH;
                disc_nxt = 1'b1;
              end
            end
            alu_pkg::OP_RJMP: begin
              // Target is PC plus one plus k
              pc_nxt   = pc_r + 15'h0001 + sext_rel(instr_rel);
              st_nxt   = alu_pkg::ST_FLUSH;
              disc_nxt = 1'b1;
            end
            default: begin
              st_nxt = alu_pkg::ST_EXEC;
            end
          endcase
        end
      end
      alu_pkg::ST_FLUSH: begin
        if (instr_valid) begin
          pc_nxt = pc_r + 15'h0001;
        end
        st_nxt = alu_pkg::ST_EXEC;
      end
      default: begin
        st_nxt = alu_pkg::ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= alu_pkg::ST_EXEC;
      acc_r  <= `ACC_RST;
      c_r    <= 1'b0;
      dc_r   <= 1'b0;
      z_r    <= 1'b0;
      pc_r   <= `PC_RST;
      we_r   <= 1'b0;
      wd_r   <= 8'h00;
      wa_r   <= 7'h00;
      disc_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      acc_r  <= acc_nxt;
      c_r    <= c_nxt;
      dc_r   <= dc_nxt;
      z_r    <= z_nxt;
      pc_r   <= pc_nxt;
      we_r   <= we_nxt;
      wd_r   <= wd_nxt;
      wa_r   <= wa_nxt;
      disc_r <= disc_nxt;
    end
  end

  // Write-back port shares the read address only when no write is pending
  assign file_addr            = we_r ? wa_r : instr_faddr;
  assign file_we              = we_r;
  assign file_wdata           = wd_r;
  assign acc                  = acc_r;
  assign carry                = c_r;
  assign nibble_overflow_flag = dc_r;
  assign zero                 = z_r;
  assign pc                   = pc_r;
  assign busy                 = (st_r == alu_pkg::ST_FLUSH);
  assign discard_next         = disc_r;
endmodule

// ==== inc/alu_consts.svh ====
/*
 * Constants for the file-register ALU and branch datapath.
 * Assumes it is included by the package and the design modules alike.
 */
// Functional notes
// - Add accumulator and file register; destination bit routes result; C, DC, Z update.
// - Add accumulator, file register and carry; route as addition; C, DC, Z update.
// - Shift right: source bit 0 into carry, bits 7..1 to 6..0; C, Z only.
// - Shift keeps source bit 7 as result bit 7; destination bit routes result.
// - Bit clear forces selected bit to zero; other bits and flags unchanged.
// - Skip if bit low: zero discards next instruction as NOP, two cycles.
// - Relative jump: sign-extended 9-bit literal added to PC plus one.
// - Relative jump always takes two cycles; second cycle is a NOP.
// - PC change or true test costs two cycles, second executed as NOP.
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define DATA_W      8
`define FADDR_W     7
`define PC_W        15
`define REL_W       9
`define NIB_MSB     3
`define STATUS_RST  3'h0
`define ACC_RST     8'h00
`define PC_RST      15'h0000
`endif

// ==== inc/alu_pkg.sv ====
/*
 * Types for the file-register ALU and branch datapath.
 * Assumes alu_consts.svh is on the include path.
 */
`include "alu_consts.svh"
package alu_pkg;
  typedef enum logic [2:0] {
    OP_ADD  = 3'h0,
    OP_ADDC = 3'h1,
    OP_ASR  = 3'h2,
    OP_BCLR = 3'h3,
    OP_SKPL = 3'h4,
    OP_RJMP = 3'h5,
    OP_NOP  = 3'h6
  } op_t;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'h1,
    ST_FLUSH = 2'h2
  } exec_state_t;
endpackage

// ==== inc/alu_if.sv ====
/*
 * Carrier between the sequencer and the arithmetic unit.
 * Assumes both ends share one clock domain.
 */
`timescale 1ns/1ps
`include "alu_consts.svh"
interface alu_if;
  alu_pkg::op_t        op;
  logic [7:0]          acc;
  logic [7:0]          fval;
  logic [2:0]          bit_sel;
  logic                carry_in;
  logic [7:0]          result;
  logic                carry_out;
  logic                nib_out;
  logic                zero_out;
  logic                writes_c;
  logic                writes_dcz;
  logic                writes_z;
  logic                test_low;
  modport seq (output op, acc, fval, bit_sel, carry_in,
               input result, carry_out, nib_out, zero_out, writes_c, writes_dcz, writes_z,
               test_low);
  modport unit (input op, acc, fval, bit_sel, carry_in,
                output result, carry_out, nib_out, zero_out, writes_c, writes_dcz, writes_z,
                test_low);
endinterface

// ==== hw/alu_unit.sv ====
/*
 * Combinational arithmetic for the supported operations.
 * Assumes operands are stable for the cycle the sequencer samples them.
 */
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_unit (
  alu_if.unit a
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic       cin;

  always_comb begin
    cin          = (a.op == alu_pkg::OP_ADDC) ? a.carry_in : 1'b0;
    low_sum      = {1'b0, a.acc[3:0]} + {1'b0, a.fval[3:0]} + {4'h0, cin};
    full_sum     = {1'b0, a.acc} + {1'b0, a.fval} + {8'h00, cin};
    a.result     = a.fval;
    a.carry_out  = a.carry_in;
    a.nib_out    = low_sum[4];
    a.writes_c   = 1'b0;
    a.writes_dcz = 1'b0;
    a.writes_z   = 1'b0;
    a.test_low   = ~a.fval[a.bit_sel];
    case (a.op)
      alu_pkg::OP_ADD, alu_pkg::OP_ADDC: begin
        a.result     = full_sum[7:0];
        a.carry_out  = full_sum[8];
        a.writes_c   = 1'b1;
        a.writes_dcz = 1'b1;
        a.writes_z   = 1'b1;
      end
      alu_pkg::OP_ASR: begin
        a.result    = {a.fval[7], a.fval[7:1]};
        a.carry_out = a.fval[0];
        a.writes_c  = 1'b1;
        a.writes_z  = 1'b1;
      end
      alu_pkg::OP_BCLR: begin
        a.result = a.fval & ~(8'h01 << a.bit_sel);
      end
      default: begin
        a.result = a.fval;
      end
    endcase
    a.zero_out = (a.result == 8'h00);
  end
endmodule

// ==== dv/alu_chk.sv ====
/*
 * Assertion checker for alu_branch_core, bound to its ports.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module alu_chk (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // Decoded instruction
  input wire logic         instr_valid,
  input wire alu_pkg::op_t instr_op,
  input wire logic         instr_dest,
  input wire logic [2:0]   instr_bit,
  input wire logic [8:0]   instr_rel,
  input wire logic [7:0]   file_rdata,
  // State and flow
  input wire logic [7:0]   acc,
  input wire logic         carry,
  input wire logic         nibble_overflow_flag,
  input wire logic         zero,
  input wire logic [14:0]  pc,
  input wire logic         busy,
  input wire logic         discard_next
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = instr_valid && !busy;
  sequence flush_s;
    busy && discard_next ##1 !busy;
  endsequence
  add_to_acc_a: assert property (tk && instr_op == alu_pkg::OP_ADD && !instr_dest |=>
    acc == 8'($past(acc) + $past(file_rdata)) && zero == (acc == 8'h00))
    else $error("add to accumulator wrong");
  addc_carry_a: assert property (tk && instr_op == alu_pkg::OP_ADDC |=>
    carry == $past(9'(acc) + 9'(file_rdata) + 9'(carry) > 9'h0FF))
    else $error("add with carry flag wrong");
  nibble_out_a: assert property (tk && instr_op == alu_pkg::OP_ADD |=>
    nibble_overflow_flag == $past(5'(acc[3:0]) + 5'(file_rdata[3:0]) > 5'h0F))
    else $error("nibble carry wrong");
  asr_acc_a: assert property (tk && instr_op == alu_pkg::OP_ASR && !instr_dest |=>
    acc == {$past(file_rdata[7]), $past(file_rdata[7:1])} && carry == $past(file_rdata[0]))
    else $error("shift result wrong");
  skip_low_a: assert property (tk && instr_op == alu_pkg::OP_SKPL && !file_rdata[instr_bit]
    |=> flush_s)
    else $error("skip did not flush");
  skip_high_a: assert property (tk && instr_op == alu_pkg::OP_SKPL && file_rdata[instr_bit]
    |=> !busy && $stable({carry, nibble_overflow_flag, zero}))
    else $error("skip taken on set bit");
  jump_pc_a: assert property (tk && instr_op == alu_pkg::OP_RJMP |=>
    pc == 15'($past(pc) + 15'h0001 + {{6{$past(instr_rel[8])}}, $past(instr_rel)}))
    else $error("jump target wrong");
  jump_flush_a: assert property (tk && instr_op == alu_pkg::OP_RJMP |=> flush_s)
    else $error("jump not two cycles");
  // Offered word in the flush cycle must not touch acc or flags; PC still steps by one
  flush_hold_a: assert property (busy |=>
    $stable({acc, carry, nibble_overflow_flag, zero}))
    else $error("flush cycle changed state");
  flush_pc_a: assert property (busy && instr_valid |=>
    pc == 15'($past(pc) + 15'h0001))
    else $error("flush cycle pc wrong");
endmodule
bind alu_branch_core alu_chk i_alu_chk (.clk, .rst, .instr_valid, .instr_op, .instr_dest,
  .instr_bit, .instr_rel, .file_rdata, .acc, .carry, .nibble_overflow_flag, .zero, .pc,
  .busy, .discard_next);

// ==== dv/test_alu_branch_core.sv ====
/*
 * Self-checking bench for alu_branch_core.
 * Assumes the file array lives here and is read combinationally.
 */
`timescale 1ns/1ps
module test_alu_branch_core;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         instr_valid = 1'b0;
  logic         instr_dest = 1'b0;
  alu_pkg::op_t instr_op = alu_pkg::OP_NOP;
  logic [6:0]   instr_faddr = 7'h00;
  logic [2:0]   instr_bit = 3'h0;
  logic [8:0]   instr_rel = 9'h000;
  logic [7:0]   mem [128];
  logic [7:0]   acc;
  logic [7:0]   file_wdata;
  logic [6:0]   file_addr;
  logic [14:0]  pc;
  logic [14:0]  epc = 15'h0000;
  logic         carry, nibble_overflow_flag, zero, file_we, busy, discard_next, seen;
  int           mismatches = 0;
  int           n_tests = 0;
  int           cyc = 0;
  wire [7:0]    file_rdata = mem[file_addr];
  always #12.5 clk = ~clk;
  alu_branch_core i_alu_branch_core (.clk, .rst, .instr_valid, .instr_op, .instr_faddr,
    .instr_dest, .instr_bit, .instr_rel, .file_addr, .file_rdata, .file_we, .file_wdata,
    .acc, .carry, .nibble_overflow_flag, .zero, .pc, .busy, .discard_next);
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(posedge clk) begin
    if (file_we) mem[file_addr] <= file_wdata;
    cyc++;
    // Run needs about 80 cycles
    if (cyc == 400) begin
      mismatches++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task st(logic [10:0] e);
    chk("state", 16'(e), 16'({acc, carry, nibble_overflow_flag, zero}));
    chk("pc", 16'(epc), 16'(pc));
  endtask
  // Gap cycle after each op keeps the write-back off the next read
  task op(alu_pkg::op_t o, logic [6:0] f, logic d, logic [2:0] b, logic [8:0] k);
    @(negedge clk);
    instr_op = o;
    instr_faddr = f;
    instr_dest = d;
    instr_bit = b;
    instr_rel = k;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    seen = busy & discard_next;
    @(negedge clk);
    epc++;
  endtask
  task t_add;
    mem[5] = 8'h8F;
    mem[6] = 8'h71;
    op(alu_pkg::OP_ADD, 7'h05, 1'b0, 3'h0, 9'h000);
    st({8'h8F, 3'h0});
    op(alu_pkg::OP_ADD, 7'h06, 1'b1, 3'h0, 9'h000);
    st({8'h8F, 3'h7});
    chk("file", 16'h0000, 16'(mem[6]));
    op(alu_pkg::OP_ADDC, 7'h05, 1'b0, 3'h0, 9'h000);
    st({8'h1F, 3'h6});
  endtask
  task t_asr;
    mem[7] = 8'h81;
    mem[8] = 8'h7E;
    op(alu_pkg::OP_ASR, 7'h07, 1'b1, 3'h0, 9'h000);
    chk("file", 16'h00C0, 16'(mem[7]));
    st({8'h1F, 3'h6});
    op(alu_pkg::OP_ASR, 7'h08, 1'b0, 3'h0, 9'h000);
    st({8'h3F, 3'h2});
  endtask
  task t_bclr;
    mem[9] = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      op(alu_pkg::OP_BCLR, 7'h09, 1'b1, 3'(i), 9'h000);
      chk("file", 16'(8'(8'hFF << (i + 1))), 16'(mem[9]));
      st({8'h3F, 3'h2});
    end
  endtask
  task t_skip;
    mem[10] = 8'h04;
    op(alu_pkg::OP_SKPL, 7'h0A, 1'b0, 3'h2, 9'h000);
    chk("flush", 16'h0000, 16'(seen));
    op(alu_pkg::OP_SKPL, 7'h0A, 1'b0, 3'h0, 9'h000);
    chk("flush", 16'h0001, 16'(seen));
    st({8'h3F, 3'h2});
  endtask
  // Add offered in the flush cycle would give acc CE if it were taken
  task t_discard;
    @(negedge clk);
    instr_op = alu_pkg::OP_SKPL;
    instr_faddr = 7'h0A;
    instr_dest = 1'b0;
    instr_bit = 3'h0;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_op = alu_pkg::OP_ADD;
    instr_faddr = 7'h05;
    seen = busy & discard_next;
    @(negedge clk);
    instr_valid = 1'b0;
    epc = epc + 15'h0002;
    chk("flush", 16'h0001, 16'(seen));
    st({8'h3F, 3'h2});
  endtask
  // Reset after the other tests, then the first add offered one idle cycle after release
  task t_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    epc = 15'h0000;
    st({8'h00, 3'h0});
    op(alu_pkg::OP_ADD, 7'h05, 1'b0, 3'h0, 9'h000);
    st({8'h8F, 3'h0});
  endtask
  task t_jump;
    logic [8:0] ks [3];
    ks = '{9'h0FF, 9'h100, 9'h1FF};
    foreach (ks[i]) begin
      op(alu_pkg::OP_RJMP, 7'h00, 1'b0, 3'h0, ks[i]);
      epc = epc + {{6{ks[i][8]}}, ks[i]};
      chk("flush", 16'h0001, 16'(seen));
      st({8'h3F, 3'h2});
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_add;
    t_asr;
    t_bclr;
    t_skip;
    t_discard;
    t_jump;
    t_reset;
    give_verdict;
  end
endmodule
